// ===== alarm_pkg.sv
/*
 * Shared constants and types for the dual hysteresis alarm outputs.
 * Assumes: included before the alarm modules; no bus, no registers here.
 */
`default_nettype none

package alarm_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int unsigned RESULT_WIDTH = 14;

	// ****************************************
	// Reset values
	// ****************************************
	// Pins are released (not driven) while reset is held
	localparam logic PIN_RESET_LEVEL = 1'b0;
	localparam logic PIN_RESET_OE_N  = 1'b1;

	// ****************************************
	// Types
	// ****************************************
	// Hysteresis state of one alarm comparator
	typedef enum logic
	{
		alarm_idle,
		alarm_active
	} alarm_state_e;

	localparam alarm_state_e STATE_RESET = alarm_idle;

endpackage

`default_nettype wire

// ===== alarm_hysteresis.sv
/*
 * One hysteresis comparator: upper or lower flavour, chosen by parameter.
 * Assumes: result and thresholds are on sys_clk_in; conv_done_in is a
 * one-cycle pulse marking a finished conversion.
 */
`timescale 1ns/1ps
`default_nettype none

module alarm_hysteresis
	import alarm_pkg::*;
#(
	parameter int unsigned WIDTH    = RESULT_WIDTH,
	parameter bit          IS_UPPER = 1'b1
)
(
	input  wire logic             sys_clk_in,
	input  wire logic             nrst_in,
	input  wire logic             conv_done_in,
	input  wire logic [WIDTH-1:0] result_in,
	input  wire logic [WIDTH-1:0] trip_level_in,
	input  wire logic [WIDTH-1:0] release_level_in,
	output logic                  active_out
);

	// ****************************************
	// Parameter check
	// ****************************************
	if (WIDTH < 1 || WIDTH > 32)
	begin : g_bad_width
		$error("alarm_hysteresis: WIDTH out of range");
	end

	// ****************************************
	// Comparisons
	// ****************************************
	// Upper trips above its level and releases at or below; lower mirrors it
	wire trip_hit    = IS_UPPER ? (result_in > trip_level_in)
	                            : (result_in < trip_level_in);
	wire release_hit = IS_UPPER ? (result_in <= release_level_in)
	                            : (result_in >= release_level_in);

	alarm_state_e state;
	alarm_state_e next_state;

	// Next state is only evaluated on a finished conversion
	always_comb
	begin
		next_state = state;
		if (conv_done_in)
		begin
			case (state)
				alarm_idle:   if (trip_hit) next_state = alarm_active;
				alarm_active: if (release_hit) next_state = alarm_idle;
				default:      next_state = alarm_idle;
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			state <= STATE_RESET;
		else
			state <= next_state;
	end

	assign active_out = (state == alarm_active);

endmodule

`default_nettype wire

// ===== alarm_outputs.sv
/*
 * Dual alarm output block: two hysteresis comparators on the corrected
 * capacitance result, per-pin polarity and driver type, and the lower pin
 * shared with the temperature density stream.
 * Assumes: result, thresholds, configuration bits and the temperature
 * stream all come from logic on sys_clk_in, so none is synchronised here;
 * the pad combines each pin's level and active-low output enable.
 */
// Behaviour
// - Compare every corrected capacitance result with the programmed thresholds.
// - Both alarms run together, independent of the active output mode.
// - With both density streams selected, lower pin carries the temperature stream.
// - Alarm states change only on conversion completion, held otherwise.
// - Works in update and sleep; in sleep the host starts measurements.
// - Four 14-bit thresholds: trip and release for upper and lower.
// - Upper trips above trip level, releases at or below release level.
// - Lower trips below trip level, releases at or above release level.
// - Each pin selects push-pull or open-drain drive.
// - Polarity 0 drives pin high when active; 1 drives it low.
// - Inverted lower pin acts as second upper alarm, registers swapped.
// - Inverted upper pin acts as second lower alarm, registers swapped.
`timescale 1ns/1ps
`default_nettype none

module alarm_outputs
	import alarm_pkg::*;
#(
	parameter int unsigned WIDTH = RESULT_WIDTH
)
(
	input  wire logic             sys_clk_in,
	input  wire logic             nrst_in,
	input  wire logic             conv_done_in,
	input  wire logic [WIDTH-1:0] result_in,
	input  wire logic [WIDTH-1:0] upper_trip_level_in,
	input  wire logic [WIDTH-1:0] upper_release_level_in,
	input  wire logic [WIDTH-1:0] lower_trip_level_in,
	input  wire logic [WIDTH-1:0] lower_release_level_in,
	input  wire logic             upper_polarity_in,
	input  wire logic             upper_open_drain_in,
	input  wire logic             lower_polarity_in,
	input  wire logic             lower_open_drain_in,
	input  wire logic             both_density_sel_in,
	input  wire logic             temp_density_stream_in,
	output logic                  upper_pin_out,
	output logic                  upper_pin_oe_n_out,
	output logic                  lower_pin_out,
	output logic                  lower_pin_oe_n_out,
	output logic                  upper_active_out,
	output logic                  lower_active_out
);

	// ****************************************
	// Parameter check
	// ****************************************
	if (WIDTH != RESULT_WIDTH)
	begin : g_bad_width
		$error("alarm_outputs: thresholds are fixed at RESULT_WIDTH bits");
	end

	// ****************************************
	// Helpers
	// ****************************************
	// Pad drive for one pin: {level, oe_n}. Open drain only ever pulls low,
	// so a high level is shown by releasing the pin to the pull-up.
	function automatic logic [1:0] pin_drive(input logic level, input logic open_drain);
		logic [1:0] drive;
		drive = open_drain ? {1'b0, level} : {level, 1'b0};
		return drive;
	endfunction

	// ****************************************
	// Comparators
	// ****************************************
	logic upper_state;
	logic lower_state;

	// Both comparators see every result, whatever mode feeds the host
	alarm_hysteresis #(
		.WIDTH    (WIDTH),
		.IS_UPPER (1'b1)
	) u_upper (
		.sys_clk_in       (sys_clk_in),
		.nrst_in          (nrst_in),
		.conv_done_in     (conv_done_in),
		.result_in        (result_in),
		.trip_level_in    (upper_trip_level_in),
		.release_level_in (upper_release_level_in),
		.active_out       (upper_state)
	);

	alarm_hysteresis #(
		.WIDTH    (WIDTH),
		.IS_UPPER (1'b0)
	) u_lower (
		.sys_clk_in       (sys_clk_in),
		.nrst_in          (nrst_in),
		.conv_done_in     (conv_done_in),
		.result_in        (result_in),
		.trip_level_in    (lower_trip_level_in),
		.release_level_in (lower_release_level_in),
		.active_out       (lower_state)
	);

	// ****************************************
	// Pin mapping
	// ****************************************
	// Polarity simply inverts the pin. With the lower pin inverted, its
	// pin goes high once the result climbs to the release register and
	// falls again below the trip register: a second upper alarm for free.
	wire       upper_level = upper_state ^ upper_polarity_in;
	wire       lower_level = lower_state ^ lower_polarity_in;
	wire [1:0] upper_drive = pin_drive(upper_level, upper_open_drain_in);
	wire [1:0] lower_alarm_drive = pin_drive(lower_level, lower_open_drain_in);
	// Temperature stream is always driven push-pull on the shared pin
	wire [1:0] lower_drive = both_density_sel_in
	                       ? {temp_density_stream_in, 1'b0}
	                       : lower_alarm_drive;

	// Output flops; released during reset since config may not be valid yet
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			upper_pin_out      <= PIN_RESET_LEVEL;
			upper_pin_oe_n_out <= PIN_RESET_OE_N;
			lower_pin_out      <= PIN_RESET_LEVEL;
			lower_pin_oe_n_out <= PIN_RESET_OE_N;
		end
		else
		begin
			upper_pin_out      <= upper_drive[1];
			upper_pin_oe_n_out <= upper_drive[0];
			lower_pin_out      <= lower_drive[1];
			lower_pin_oe_n_out <= lower_drive[0];
		end
	end

	// Status copies for whoever reports alarm state; same timing as pins
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			upper_active_out <= 1'b0;
			lower_active_out <= 1'b0;
		end
		else
		begin
			upper_active_out <= upper_state;
			lower_active_out <= lower_state;
		end
	end

	// Sleep and update operation differ only in who starts a conversion;
	// this block reacts to conv_done_in alike in both.

	// ****************************************
	// Assertions
	// ****************************************
	hold_between_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		!conv_done_in |=> ($stable(upper_state) && $stable(lower_state)))
		else $error("alarm state changed without a finished conversion");

	upper_trip_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(conv_done_in && !upper_state && result_in > upper_trip_level_in) |=> upper_state)
		else $error("upper alarm failed to trip");

	upper_release_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(conv_done_in && upper_state && result_in <= upper_release_level_in)
		|=> !upper_state)
		else $error("upper alarm failed to release");

	upper_hyst_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(conv_done_in && upper_state && result_in > upper_release_level_in)
		|=> upper_state)
		else $error("upper alarm released inside hysteresis band");

	lower_trip_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(conv_done_in && !lower_state && result_in < lower_trip_level_in) |=> lower_state)
		else $error("lower alarm failed to trip");

	lower_release_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(conv_done_in && lower_state && result_in >= lower_release_level_in)
		|=> !lower_state)
		else $error("lower alarm failed to release");

	idle_no_trip_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(conv_done_in && !lower_state && result_in >= lower_trip_level_in)
		|=> !lower_state)
		else $error("lower alarm tripped at or above its trip level");

	upper_polarity_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		!upper_open_drain_in
		|=> (!upper_pin_oe_n_out && upper_pin_out == ($past(upper_state) ^ $past(upper_polarity_in))))
		else $error("upper push-pull pin level wrong for polarity");

	lower_invert_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(!both_density_sel_in && !lower_open_drain_in && lower_polarity_in && lower_state)
		|=> !lower_pin_out)
		else $error("inverted lower pin not low while alarm active");

	open_drain_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		upper_open_drain_in
		|=> (!upper_pin_out && upper_pin_oe_n_out == ($past(upper_state) ^ $past(upper_polarity_in))))
		else $error("upper open-drain pin drove high or wrong enable");

	lower_od_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(!both_density_sel_in && lower_open_drain_in)
		|=> (!lower_pin_out
		     && lower_pin_oe_n_out == ($past(lower_state) ^ $past(lower_polarity_in))))
		else $error("lower open-drain pin drove high or wrong enable");

	lower_push_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(!both_density_sel_in && !lower_open_drain_in)
		|=> (!lower_pin_oe_n_out
		     && lower_pin_out == ($past(lower_state) ^ $past(lower_polarity_in))))
		else $error("lower push-pull pin level wrong for polarity");

	temp_share_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		both_density_sel_in
		|=> (!lower_pin_oe_n_out && lower_pin_out == $past(temp_density_stream_in)))
		else $error("lower pin not carrying the temperature stream");

	status_copy_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		##1 (upper_active_out == $past(upper_state) && lower_active_out == $past(lower_state)))
		else $error("alarm status outputs out of step");

endmodule

`default_nettype wire

// ===== alarm_load.sv
/*
 * Far-side load model: a pull-up resistor on each alarm pad.
 * Assumes: the pad level is high whenever the block releases the pin.
 */
`timescale 1ns/1ps
`default_nettype none

module alarm_load
(
	input  wire logic pin_in,
	input  wire logic oe_n_in,
	output logic      pad_out
);
	// ****************************************
	// Pad resolution
	// ****************************************
	// Released pin floats up; nothing holds the last driven value
	assign pad_out = oe_n_in ? 1'b1 : pin_in;
endmodule

`default_nettype wire

// ===== dual_hysteresis_alarm_outputs_tb.sv
/*
 * Self-checking bench for the dual alarm outputs: reset values first, then a
 * table of results, then driver, polarity, stream and reset cases by hand.
 * Assumes: outputs follow a taken conversion by one further clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) checked++; if ((got) !== (ex)) begin error_cnt++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end

module dual_hysteresis_alarm_outputs_tb;
	import alarm_pkg::*;

	typedef struct packed {logic [13:0] res; logic done; logic up; logic lo;} row_s;

	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        conv_done = 1'b0;
	logic [13:0] result = 14'h1800;
	logic [13:0] up_trip = 14'h3000;
	logic [13:0] up_rel = 14'h2000;
	logic [13:0] lo_trip = 14'h0800;
	logic [13:0] lo_rel = 14'h1000;
	logic        up_pol = 1'b0;
	logic        up_od = 1'b0;
	logic        lo_pol = 1'b0;
	logic        lo_od = 1'b0;
	logic        both_sel = 1'b0;
	logic        temp_bit = 1'b0;
	logic        up_pin, up_oe_n, lo_pin, lo_oe_n, up_act, lo_act, up_pad, lo_pad;
	int          error_cnt = 0;
	int          checked = 0;
	// Thresholds: upper trip 3000 release 2000, lower trip 0800 release 1000
	row_s        rows [9] = '{
		'{14'h3000, 1'b1, 1'b0, 1'b0}, '{14'h3001, 1'b1, 1'b1, 1'b0},
		'{14'h2001, 1'b1, 1'b1, 1'b0}, '{14'h2000, 1'b1, 1'b0, 1'b0},
		'{14'h3fff, 1'b0, 1'b0, 1'b0}, '{14'h0800, 1'b1, 1'b0, 1'b0},
		'{14'h07ff, 1'b1, 1'b0, 1'b1}, '{14'h0fff, 1'b1, 1'b0, 1'b1},
		'{14'h1000, 1'b1, 1'b0, 1'b0}};

	always #12.5 sys_clk = ~sys_clk;

	alarm_outputs uut (.sys_clk_in(sys_clk), .nrst_in(nrst), .conv_done_in(conv_done),
		.result_in(result), .upper_trip_level_in(up_trip),
		.upper_release_level_in(up_rel), .lower_trip_level_in(lo_trip),
		.lower_release_level_in(lo_rel), .upper_polarity_in(up_pol),
		.upper_open_drain_in(up_od), .lower_polarity_in(lo_pol),
		.lower_open_drain_in(lo_od), .both_density_sel_in(both_sel),
		.temp_density_stream_in(temp_bit), .upper_pin_out(up_pin),
		.upper_pin_oe_n_out(up_oe_n), .lower_pin_out(lo_pin),
		.lower_pin_oe_n_out(lo_oe_n), .upper_active_out(up_act),
		.lower_active_out(lo_act));
	alarm_load up_load (.pin_in(up_pin), .oe_n_in(up_oe_n), .pad_out(up_pad));
	alarm_load lo_load (.pin_in(lo_pin), .oe_n_in(lo_oe_n), .pad_out(lo_pad));

	// ****************************************
	// Helpers
	// ****************************************
	// Inputs move a fixed 2 ns after the edge so no race with sampling
	task tick;
		@(posedge sys_clk);
		#2;
	endtask

	// Drive conv_done to d for one cycle (a conversion only when d is set), then wait for the outputs to land
	task do_conv(input logic [13:0] r, input logic d);
		result = r;
		conv_done = d;
		tick;
		conv_done = 1'b0;
		tick;
	endtask

	task end_of_test;
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard well beyond the whole sequence
	initial
	begin
		#50000;
		error_cnt++;
		end_of_test;
	end

	initial
	begin
		repeat (12) tick;
		`CHK("upper oe_n in reset", 1'b1, up_oe_n)
		`CHK("lower active in reset", 1'b0, lo_act)
		nrst = 1'b1;
		tick;
		`CHK("upper pad idle", 1'b0, up_pad)
		foreach (rows[i])
		begin
			do_conv(rows[i].res, rows[i].done);
			`CHK("upper active", rows[i].up, up_act)
			`CHK("lower active", rows[i].lo, lo_act)
			`CHK("upper pad", rows[i].up, up_pad)
			`CHK("lower pad", rows[i].lo, lo_pad)
		end
		// Open drain upper: pulled low idle, released when tripped
		up_od = 1'b1;
		tick;
		`CHK("od idle oe_n", 1'b0, up_oe_n)
		do_conv(14'h3100, 1'b1);
		`CHK("od active oe_n", 1'b1, up_oe_n)
		// Inverted polarity turns each pin into the opposite kind of alarm
		up_od = 1'b0;
		up_pol = 1'b1;
		lo_pol = 1'b1;
		do_conv(14'h0100, 1'b1);
		`CHK("inv upper pad", 1'b1, up_pad)
		`CHK("inv lower pad", 1'b0, lo_pad)
		do_conv(14'h3100, 1'b1);
		`CHK("inv upper pad hi", 1'b0, up_pad)
		`CHK("inv lower pad hi", 1'b1, lo_pad)
		// Temperature stream takes over the lower pin
		both_sel = 1'b1;
		temp_bit = 1'b1;
		tick;
		`CHK("stream one", 1'b1, lo_pad)
		temp_bit = 1'b0;
		tick;
		`CHK("stream zero", 1'b0, lo_pad)
		do_conv(14'h0100, 1'b1);
		`CHK("upper with stream", 1'b1, up_pad)
		// Mid-run reset drops both alarms and releases the pins
		nrst = 1'b0;
		tick;
		`CHK("reset upper active", 1'b0, up_act)
		`CHK("reset lower oe_n", 1'b1, lo_oe_n)
		nrst = 1'b1;
		tick;
		`CHK("post reset upper pad", 1'b1, up_pad)
		// Stream stays push-pull even with the lower pin set to open drain
		lo_od = 1'b1;
		temp_bit = 1'b1;
		tick;
		`CHK("stream od oe_n", 1'b0, lo_oe_n)
		`CHK("stream od pin", 1'b1, lo_pin)
		// Lower open drain alarm, with new thresholds on both alarms
		both_sel = 1'b0;
		lo_pol = 1'b0;
		up_pol = 1'b0;
		up_trip = 14'h2aaa;
		up_rel = 14'h1555;
		lo_trip = 14'h1555;
		lo_rel = 14'h2aaa;
		tick;
		`CHK("lower od idle oe_n", 1'b0, lo_oe_n)
		`CHK("lower od idle pin", 1'b0, lo_pin)
		do_conv(14'h2aab, 1'b1);
		`CHK("new upper trip", 1'b1, up_act)
		`CHK("new upper pin", 1'b1, up_pin)
		do_conv(14'h1554, 1'b1);
		`CHK("new upper release", 1'b0, up_act)
		`CHK("new lower trip", 1'b1, lo_act)
		`CHK("lower od released", 1'b1, lo_oe_n)
		`CHK("lower od pad", 1'b1, lo_pad)
		end_of_test;
	end
endmodule

`default_nettype wire
